// [backup_cfg_regs.sv]
// Register bank with serial slave, nonvolatile mirror and capacitance counter.
// Function
// - Discharge current source runs during measurement; 20 mA select when field is 11.
// - Counter on 500 Hz ticks starts at start level, stops at stop level.
// - Setting write enable copies registers 01H to 06H into nonvolatile store.
// - Power-up loads nonvolatile store contents into the registers.
// - Control bit 2 is read-only busy, 1 while store write runs.
// - Control bit 0 is write enable, 1 enables, resets to 0.
// - Slave answers at 59H, or 5AH or 5BH, plus direction bit.
// - Load switch register defaults to 38H, switch and converter disabled.
// - Load switch bits 5:3 current limit, bit 0 enable, bits 7 and 2 reserved.
// - Nonvolatile control register at 00H, bits 7:3 and 1 reserved.
// - Load switch register at 01H.
// - Measurement starts only on 0-to-1 of enable bit, default 0.
// - Stop level register at 05H, 8 bits, default 2FH.
`timescale 1ns/1ns
`default_nettype none
module backup_cfg_regs #(
  parameter int TICK_CYCLES = backup_cfg_pkg::COUNT_TICK_CYCLES,
  parameter int COUNT_WIDTH = 16
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe,
  input  wire logic [1:0]             addr_select,
  input  wire logic                   below_start_level,
  input  wire logic                   below_stop_level,
  output logic                        discharge_on,
  output logic                        discharge_20ma,
  output logic                        switch_enable_bit,
  output logic [2:0]                  current_limit_code,
  output logic [7:0]                  converter_param,
  output logic [7:0]                  buck_off_level,
  output logic [7:0]                  discharge_start_level,
  output logic [7:0]                  discharge_stop_level,
  output logic [7:0]                  freq_config_bits,
  output logic                        nv_busy
);
  import backup_cfg_pkg::*;

  logic [7:0]       cfg [CFG_FIRST:CFG_LAST];
  logic [7:0]       nonvolatile_store [CFG_FIRST:CFG_LAST];
  logic             nv_write_en;
  nv_state_t        nv_state;
  logic [2:0]       nv_index;
  logic [4:0]       nv_wait;
  meas_state_t      meas_state;
  logic [COUNT_WIDTH-1:0] meas_count;
  logic [COUNT_WIDTH-1:0] meas_result;
  logic [15:0]      tick_div;
  logic             tick;
  logic             meas_en_prev;
  bus_state_t       bus_state;
  logic             scl_prev;
  logic             sda_prev;
  logic [3:0]       bit_cnt;
  logic [7:0]       shreg;
  logic [7:0]       reg_ptr;
  logic             master_nack;
  logic             reg_wr;
  logic [7:0]       reg_wr_data;
  logic [6:0]       own_addr;
  logic             scl_rise;
  logic             scl_fall;
  logic             bus_start;
  logic             bus_stop;
  logic             meas_start;
  logic [7:0]       rd_now;
  logic [7:0]       rd_next;
  logic [7:0]       ctrl_view;

  function automatic logic [7:0] reset_value(input int idx);
    case (idx)
      1: reset_value = RST_LOAD_SWITCH;
      2: reset_value = RST_CONVERTER;
      3: reset_value = RST_BUCK_OFF;
      4: reset_value = RST_DIS_START;
      5: reset_value = RST_DIS_STOP;
      default: reset_value = RST_FREQ_CONFIG;
    endcase
  endfunction

  function automatic logic [7:0] write_mask(input logic [7:0] addr);
    case (addr)
      ADDR_LOAD_SWITCH: write_mask = MASK_LOAD_SWITCH;
      ADDR_FREQ_CONFIG: write_mask = MASK_FREQ_CONFIG;
      default:          write_mask = 8'hFF;
    endcase
  endfunction

  function automatic logic [7:0] read_value(input logic [7:0] addr);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      ADDR_NV_CONTROL: begin
        v[CTRL_WRITE_EN_BIT] = nv_write_en;
        v[CTRL_BUSY_BIT]     = nv_busy;
      end
      ADDR_LOAD_SWITCH, ADDR_CONVERTER, ADDR_BUCK_OFF, ADDR_DIS_START,
      ADDR_DIS_STOP, ADDR_FREQ_CONFIG: v = cfg[addr[2:0]];
      ADDR_RESULT_LOW:  v = meas_result[7:0];
      ADDR_RESULT_HIGH: v = meas_result[15:8];
      default:          v = 8'h00;
    endcase
    read_value = v;
  endfunction

  // Read data for the current and the next pointer, so its top bit can be picked directly.
  always_comb begin
    rd_now    = read_value(reg_ptr);
    rd_next   = read_value(reg_ptr + 8'd1);
    ctrl_view = read_value(ADDR_NV_CONTROL);
  end

  // Bus pin edges; pins are already synchronous to core_clk.
  assign scl_rise  = scl_in && !scl_prev;
  assign scl_fall  = !scl_in && scl_prev;
  assign bus_start = scl_in && scl_prev && sda_prev && !sda_in;
  assign bus_stop  = scl_in && scl_prev && !sda_prev && sda_in;
  assign sda_out   = 1'b0;

  always_comb begin
    case (addr_select)
      2'b01:   own_addr = SLAVE_ADDR_1;
      2'b10:   own_addr = SLAVE_ADDR_2;
      default: own_addr = SLAVE_ADDR_0;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_in;
      sda_prev <= sda_in;
    end
  end

  // Serial slave: bits shift on SCL rise, SDA changes after SCL fall.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_state   <= BUS_IDLE;
      bit_cnt     <= 4'h0;
      shreg       <= 8'h00;
      reg_ptr     <= 8'h00;
      sda_oe      <= 1'b0;
      master_nack <= 1'b0;
      reg_wr      <= 1'b0;
      reg_wr_data <= 8'h00;
    end else begin
      reg_wr <= 1'b0;
      if (bus_start) begin
        bus_state <= BUS_ADDR;
        bit_cnt   <= 4'h0;
        sda_oe    <= 1'b0;
      end else if (bus_stop) begin
        bus_state <= BUS_IDLE;
        sda_oe    <= 1'b0;
      end else if (scl_rise && bus_state != BUS_IDLE) begin
        if (bus_state != BUS_RDATA && bit_cnt < 4'd8) begin
          shreg   <= {shreg[6:0], sda_in};
          bit_cnt <= bit_cnt + 4'd1;
        end else if (bus_state == BUS_RDATA && bit_cnt == 4'd8) begin
          master_nack <= sda_in;
        end
      end else if (scl_fall) begin
        case (bus_state)
          BUS_ADDR, BUS_PTR, BUS_WDATA: begin
            if (bit_cnt == 4'd8) begin
              bit_cnt <= 4'd9;
              sda_oe  <= 1'b1;
              if (bus_state == BUS_ADDR && shreg[7:1] != own_addr) begin
                bus_state <= BUS_IDLE;
                sda_oe    <= 1'b0;
              end else if (bus_state == BUS_PTR) begin
                reg_ptr <= shreg;
              end else if (bus_state == BUS_WDATA) begin
                reg_wr      <= 1'b1;
                reg_wr_data <= shreg;
              end
            end else if (bit_cnt == 4'd9) begin
              bit_cnt <= 4'h0;
              sda_oe  <= 1'b0;
              if (bus_state == BUS_ADDR && shreg[0]) begin
                bus_state   <= BUS_RDATA;
                shreg       <= rd_now;
                sda_oe      <= !rd_now[7];
                master_nack <= 1'b0;
              end else if (bus_state == BUS_ADDR) begin
                bus_state <= BUS_PTR;
              end else if (bus_state == BUS_PTR) begin
                bus_state <= BUS_WDATA;
              end else begin
                reg_ptr <= reg_ptr + 8'd1;
              end
            end
          end
          BUS_RDATA: begin
            if (bit_cnt < 4'd7) begin
              shreg   <= {shreg[6:0], 1'b0};
              sda_oe  <= !shreg[6];
              bit_cnt <= bit_cnt + 4'd1;
            end else if (bit_cnt == 4'd7) begin
              sda_oe  <= 1'b0;
              bit_cnt <= 4'd8;
            end else if (master_nack) begin
              bus_state <= BUS_IDLE;
            end else begin
              bit_cnt <= 4'h0;
              reg_ptr <= reg_ptr + 8'd1;
              shreg   <= rd_next;
              sda_oe  <= !rd_next[7];
            end
          end
          default: sda_oe <= 1'b0;
        endcase
      end
    end
  end

  // Configuration registers; loaded from the store after power-up.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = CFG_FIRST; i <= CFG_LAST; i++) begin
        // Load switch defaults, stop level default.
        cfg[i] <= reset_value(i);
      end
    end else if (nv_state == NV_LOAD) begin
      cfg[nv_index] <= nonvolatile_store[nv_index];
    end else if (reg_wr && reg_ptr >= ADDR_LOAD_SWITCH && reg_ptr <= ADDR_FREQ_CONFIG) begin
      cfg[reg_ptr[2:0]] <= reg_wr_data & write_mask(reg_ptr);
    end
  end

  // Nonvolatile control: power-up load, then one byte per program interval.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nv_state    <= NV_LOAD;
      nv_index    <= 3'(CFG_FIRST);
      nv_wait     <= 5'h0;
      nv_busy     <= 1'b0;
      nv_write_en <= 1'b0;
      for (int i = CFG_FIRST; i <= CFG_LAST; i++) begin
        nonvolatile_store[i] <= reset_value(i);
      end
    end else begin
      case (nv_state)
        NV_LOAD: begin
          if (nv_index == 3'(CFG_LAST)) begin
            nv_state <= NV_IDLE;
          end else begin
            nv_index <= nv_index + 3'd1;
          end
        end
        NV_IDLE: begin
          // Write enable at 00H bit 0.
          if (reg_wr && reg_ptr == ADDR_NV_CONTROL && reg_wr_data[CTRL_WRITE_EN_BIT]) begin
            nv_write_en <= 1'b1;
            nv_busy     <= 1'b1;
            nv_state    <= NV_PROG;
            nv_index    <= 3'(CFG_FIRST);
            nv_wait     <= 5'h0;
          end
        end
        NV_PROG: begin
          if (nv_wait == 5'(NV_BYTE_CYCLES - 1)) begin
            // Copy one register into the store.
            nonvolatile_store[nv_index] <= cfg[nv_index];
            nv_wait <= 5'h0;
            if (nv_index == 3'(CFG_LAST)) begin
              // Busy and enable clear at the end.
              nv_busy     <= 1'b0;
              nv_write_en <= 1'b0;
              nv_state    <= NV_IDLE;
            end else begin
              nv_index <= nv_index + 3'd1;
            end
          end else begin
            nv_wait <= nv_wait + 5'd1;
          end
        end
        default: nv_state <= NV_IDLE;
      endcase
    end
  end

  // Divider for the 500 Hz counter clock.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_div <= 16'h0000;
      tick     <= 1'b0;
    end else if (tick_div == 16'(TICK_CYCLES - 1)) begin
      tick_div <= 16'h0000;
      tick     <= 1'b1;
    end else begin
      tick_div <= tick_div + 16'd1;
      tick     <= 1'b0;
    end
  end

  // Start on a rising edge of the enable bit only.
  assign meas_start = cfg[ADDR_FREQ_CONFIG[2:0]][FREQ_MEAS_EN_BIT] && !meas_en_prev;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meas_en_prev   <= 1'b0;
      meas_state     <= MEAS_IDLE;
      meas_count     <= '0;
      meas_result    <= '0;
      discharge_on   <= 1'b0;
      discharge_20ma <= 1'b0;
    end else begin
      meas_en_prev <= cfg[ADDR_FREQ_CONFIG[2:0]][FREQ_MEAS_EN_BIT];
      case (meas_state)
        MEAS_IDLE: begin
          if (meas_start) begin
            meas_state <= MEAS_WAIT;
            meas_count <= '0;
            discharge_on <= 1'b1;
          end
        end
        MEAS_WAIT: begin
          if (below_start_level) begin
            meas_state <= MEAS_COUNT;
          end
        end
        MEAS_COUNT: begin
          // Stop at the stop level. Hold the result.
          if (below_stop_level) begin
            meas_state   <= MEAS_IDLE;
            meas_result  <= meas_count;
            discharge_on <= 1'b0;
          end else if (tick) begin
            meas_count <= meas_count + 1'b1;
          end
        end
        default: meas_state <= MEAS_IDLE;
      endcase
      // Current select follows the converter field while the discharge source is on.
      discharge_20ma <= (meas_state != MEAS_IDLE || meas_start) && !(meas_state == MEAS_COUNT
                        && below_stop_level) && cfg[ADDR_CONVERTER[2:0]][7:6] == DISCHARGE_20MA;
    end
  end

  assign switch_enable_bit     = cfg[ADDR_LOAD_SWITCH[2:0]][0];
  assign current_limit_code    = cfg[ADDR_LOAD_SWITCH[2:0]][5:3];
  assign converter_param       = cfg[ADDR_CONVERTER[2:0]];
  assign buck_off_level        = cfg[ADDR_BUCK_OFF[2:0]];
  assign discharge_start_level = cfg[ADDR_DIS_START[2:0]];
  assign discharge_stop_level  = cfg[ADDR_DIS_STOP[2:0]];
  assign freq_config_bits      = cfg[ADDR_FREQ_CONFIG[2:0]];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_busy_in_prog: assert property (nv_busy == (nv_state == NV_PROG))
    else $error("busy flag disagrees with store write state");
  a_busy_readback: assert property (ctrl_view[CTRL_BUSY_BIT] == nv_busy)
    else $error("control bit 2 does not show busy");
  a_write_starts: assert property ($rose(nv_busy) |-> $past(reg_wr && reg_ptr == ADDR_NV_CONTROL))
    else $error("store write began without a control write");
  a_prog_length: assert property ($rose(nv_busy) |-> nv_busy [*8])
    else $error("store write ended too early");
  a_busy_end: assert property ($fell(nv_busy) |-> !nv_write_en && nv_state == NV_IDLE)
    else $error("enable bit not cleared at end of store write");
  a_meas_edge: assert property ($rose(discharge_on) |-> $past(meas_start))
    else $error("measurement started without an enable edge");
  a_count_stop: assert property (meas_state == MEAS_COUNT && below_stop_level
                                 |=> meas_state == MEAS_IDLE && !discharge_on)
    else $error("counter did not stop at the stop level");
  a_count_idle: assert property (meas_state != MEAS_COUNT |=> $stable(meas_count) || meas_count == '0)
    else $error("counter moved outside the counting window");
  a_result_hold: assert property (meas_state == MEAS_IDLE && !meas_start |=> $stable(meas_result))
    else $error("result changed while idle");
  a_current_sel: assert property (discharge_20ma |-> discharge_on)
    else $error("20 mA select without discharge");
  a_reserved_zero: assert property ((cfg[ADDR_LOAD_SWITCH[2:0]] & ~MASK_LOAD_SWITCH) == 8'h00)
    else $error("reserved load switch bits set");

  c_store_write: cover property ($fell(nv_busy));
  c_measurement: cover property (meas_state == MEAS_COUNT ##1 meas_state == MEAS_IDLE);
  c_read_byte: cover property (bus_state == BUS_RDATA && bit_cnt == 4'd8 && scl_fall);
endmodule // backup_cfg_regs
`default_nettype wire

// [backup_cfg_pkg.sv]
// Constants shared by the backup power configuration register bank.
package backup_cfg_pkg;
  // Register addresses.
  localparam logic [7:0] ADDR_NV_CONTROL   = 8'h00;
  localparam logic [7:0] ADDR_LOAD_SWITCH  = 8'h01;
  localparam logic [7:0] ADDR_CONVERTER    = 8'h02;
  localparam logic [7:0] ADDR_BUCK_OFF     = 8'h03;
  localparam logic [7:0] ADDR_DIS_START    = 8'h04;
  localparam logic [7:0] ADDR_DIS_STOP     = 8'h05;
  localparam logic [7:0] ADDR_FREQ_CONFIG  = 8'h06;
  localparam logic [7:0] ADDR_RESULT_LOW   = 8'h07;
  localparam logic [7:0] ADDR_RESULT_HIGH  = 8'h08;
  localparam int         CFG_FIRST         = 1;
  localparam int         CFG_LAST          = 6;
  // Values after reset.
  localparam logic [7:0] RST_LOAD_SWITCH   = 8'h38;
  localparam logic [7:0] RST_CONVERTER     = 8'hC5;
  localparam logic [7:0] RST_BUCK_OFF      = 8'h37;
  localparam logic [7:0] RST_DIS_START     = 8'h46;
  localparam logic [7:0] RST_DIS_STOP      = 8'h2F;
  localparam logic [7:0] RST_FREQ_CONFIG   = 8'h01;
  // Writable bit masks; reserved bits read as zero.
  localparam logic [7:0] MASK_LOAD_SWITCH  = 8'h7B;
  localparam logic [7:0] MASK_FREQ_CONFIG  = 8'h2F;
  // Field positions.
  localparam int         CTRL_WRITE_EN_BIT = 0;
  localparam int         CTRL_BUSY_BIT     = 2;
  localparam int         FREQ_MEAS_EN_BIT  = 5;
  localparam logic [1:0] DISCHARGE_20MA    = 2'b11;
  // Slave addresses, 7 bit.
  localparam logic [6:0] SLAVE_ADDR_0      = 7'h59;
  localparam logic [6:0] SLAVE_ADDR_1      = 7'h5A;
  localparam logic [6:0] SLAVE_ADDR_2      = 7'h5B;
  // Timing.
  localparam int         CORE_CLK_HZ       = 10_000_000;
  localparam int         COUNT_CLK_HZ      = 500;
  localparam int         COUNT_TICK_CYCLES = CORE_CLK_HZ / COUNT_CLK_HZ;
  localparam int         NV_BYTE_CYCLES    = 16;
  typedef enum logic [1:0] {
    NV_LOAD = 2'b00,
    NV_IDLE = 2'b01,
    NV_PROG = 2'b10
  } nv_state_t;
  typedef enum logic [1:0] {
    MEAS_IDLE  = 2'b00,
    MEAS_WAIT  = 2'b01,
    MEAS_COUNT = 2'b10
  } meas_state_t;
  typedef enum logic [2:0] {
    BUS_IDLE  = 3'b000,
    BUS_ADDR  = 3'b001,
    BUS_PTR   = 3'b010,
    BUS_WDATA = 3'b011,
    BUS_RDATA = 3'b100
  } bus_state_t;
endpackage

// [i2c_host_model.sv]
// Serial bus master standing in for the host controller on the slave's bus.
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model (
  input  wire logic       core_clk,
  input  wire logic       sda,
  output logic            scl,
  output logic            sda_low,
  output logic            res_valid,
  output logic [7:0]      res_data
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    res_valid = 1'b0;
    res_data = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Data changes only while the serial clock is low; each phase lasts eight cycles.
  task automatic put_bit(input logic b);
    sda_low = ~b;
    tick(4);
    scl = 1'b1;
    tick(8);
    scl = 1'b0;
    tick(4);
  endtask
  // A released line is pulled high, so an absent answer reads as one.
  task automatic get_bit(output logic b);
    sda_low = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    b = sda;
    tick(4);
    scl = 1'b0;
    tick(4);
  endtask
  task automatic start();
    if (scl === 1'b0) begin
      sda_low = 1'b0;
      tick(4);
      scl = 1'b1;
      tick(4);
    end
    sda_low = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(4);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(8);
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(b);
    ack = ~b;
  endtask
  task automatic recv_byte(input logic last);
    logic [7:0] d;
    logic       b;
    for (int i = 7; i >= 0; i--) begin
      get_bit(b);
      d[i] = b;
    end
    put_bit(last);
    res_data = d;
    res_valid = 1'b1;
    tick(1);
    res_valid = 1'b0;
  endtask
  task automatic write_regs(input logic [6:0] dev, input logic [7:0] ptr,
                            input logic [7:0] d [$], output logic ack);
    logic a;
    start();
    send_byte({dev, 1'b0}, ack);
    send_byte(ptr, a);
    foreach (d[i]) begin
      send_byte(d[i], a);
    end
    stop();
  endtask
  // Pointer write, repeated start, then reads.
  task automatic read_regs(input logic [6:0] dev, input logic [7:0] ptr, input int n,
                           output logic ack);
    logic a;
    start();
    send_byte({dev, 1'b0}, ack);
    send_byte(ptr, a);
    start();
    send_byte({dev, 1'b1}, a);
    for (int i = 0; i < n; i++) begin
      recv_byte(i == n - 1);
    end
    stop();
  endtask
endmodule // i2c_host_model
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the backup power configuration register bank.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import backup_cfg_pkg::*;
  localparam int TICKS = 4;
  typedef struct {string name; logic [7:0] exp; int tol;} note_t;
  logic        core_clk, rst, scl, host_low, sda_line, sda_out, sda_oe;
  logic        below_start, below_stop, discharge_on, discharge_20ma;
  logic        switch_enable_bit, nv_busy, res_valid;
  logic [1:0]  addr_select;
  logic [2:0]  current_limit_code;
  logic [7:0]  converter_param, buck_off_level, dis_start, dis_stop, freq_cfg, res_data, v;
  logic [6:0]  dev;
  logic [15:0] lfsr = 16'h3EF0;
  logic [7:0]  exp_store [7];
  int          num_errors, check_count, cycles, busy_run, busy_len, n;
  note_t       notes [$];
  logic [6:0]  slv [3] = '{SLAVE_ADDR_0, SLAVE_ADDR_1, SLAVE_ADDR_2};
  logic [7:0]  rst_vals [7] = '{8'h00, RST_LOAD_SWITCH, RST_CONVERTER, RST_BUCK_OFF,
                                RST_DIS_START, RST_DIS_STOP, RST_FREQ_CONFIG};

  assign sda_line = ~(host_low | (sda_oe & ~sda_out));

  backup_cfg_regs #(.TICK_CYCLES(TICKS), .COUNT_WIDTH(16)) u_dut (
    .core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_select(addr_select), .below_start_level(below_start),
    .below_stop_level(below_stop), .discharge_on(discharge_on),
    .discharge_20ma(discharge_20ma), .switch_enable_bit(switch_enable_bit),
    .current_limit_code(current_limit_code), .converter_param(converter_param),
    .buck_off_level(buck_off_level), .discharge_start_level(dis_start),
    .discharge_stop_level(dis_stop), .freq_config_bits(freq_cfg), .nv_busy(nv_busy));

  i2c_host_model u_host (
    .core_clk(core_clk), .sda(sda_line), .scl(scl), .sda_low(host_low),
    .res_valid(res_valid), .res_data(res_data));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic results();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic ok, input logic [7:0] e,
                     input logic [7:0] s);
    check_count++;
    if (ok !== 1'b1) begin
      $display("CHECK FAILED %s expected %h seen %h", name, e, s);
      num_errors++;
    end
  endtask
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction
  task automatic note(input string name, input logic [7:0] e, input int tol);
    note_t x;
    x.name = name;
    x.exp = e;
    x.tol = tol;
    notes.push_back(x);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d [$]);
    logic ack;
    u_host.write_regs(dev, ptr, d, ack);
    chk("write ack", ack === 1'b1, 8'h01, {7'h00, ack});
  endtask
  task automatic rd(input logic [7:0] ptr, input int k);
    logic ack;
    u_host.read_regs(dev, ptr, k, ack);
    chk("read ack", ack === 1'b1, 8'h01, {7'h00, ack});
  endtask

  // Each read byte is compared with the oldest noted expectation.
  always @(posedge res_valid) begin
    note_t x;
    if (notes.size() == 0) begin
      chk("unexpected read", 1'b0, 8'h00, res_data);
    end else begin
      x = notes.pop_front();
      chk(x.name, (res_data + x.tol >= x.exp) && (res_data <= x.exp + x.tol), x.exp, res_data);
    end
  end

  always @(posedge core_clk) begin
    cycles++;
    if (nv_busy === 1'b1) begin
      busy_run++;
    end else if (busy_run != 0) begin
      busy_len = busy_run;
      busy_run = 0;
    end
    if (cycles == 60000) begin
      chk("timeout", 1'b0, 8'h00, 8'h00);
      results();
    end
  end

  initial begin
    logic ack;
    rst = 1'b1;
    addr_select = 2'b00;
    below_start = 1'b0;
    below_stop = 1'b0;
    dev = SLAVE_ADDR_0;
    cyc(2);
    rst = 1'b0;
    cyc(10);
    chk("switch enable", switch_enable_bit === 1'b0, 8'h00, {7'h00, switch_enable_bit});
    chk("limit code", current_limit_code === 3'b111, 8'h07, {5'h00, current_limit_code});
    chk("stop level", dis_stop === RST_DIS_STOP, RST_DIS_STOP, dis_stop);
    chk("converter", converter_param === RST_CONVERTER, RST_CONVERTER, converter_param);
    chk("buck off", buck_off_level === RST_BUCK_OFF, RST_BUCK_OFF, buck_off_level);
    chk("start level", dis_start === RST_DIS_START, RST_DIS_START, dis_start);
    chk("freq config", freq_cfg === RST_FREQ_CONFIG, RST_FREQ_CONFIG, freq_cfg);
    foreach (rst_vals[i]) note("reset value", rst_vals[i], 0);
    rd(ADDR_NV_CONTROL, 7);
    for (int s = 0; s < 3; s++) begin
      addr_select = s[1:0];
      dev = slv[s];
      note("strap read", RST_LOAD_SWITCH, 0);
      rd(ADDR_LOAD_SWITCH, 1);
      note("foreign read", 8'hFF, 0);
      u_host.read_regs(slv[(s + 1) % 3], ADDR_LOAD_SWITCH, 1, ack);
      chk("foreign ack", ack === 1'b0, 8'h00, {7'h00, ack});
    end
    addr_select = 2'b00;
    dev = SLAVE_ADDR_0;
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : rnd();
      wr(ADDR_LOAD_SWITCH, '{v});
      chk("switch enable", switch_enable_bit === v[0], v, {7'h00, switch_enable_bit});
      chk("limit code", current_limit_code === v[5:3], v, {5'h00, current_limit_code});
      note("load switch", v & MASK_LOAD_SWITCH, 0);
      rd(ADDR_LOAD_SWITCH, 1);
    end
    exp_store = rst_vals;
    exp_store[1] = v & MASK_LOAD_SWITCH;
    v = rnd();
    wr(ADDR_DIS_START, '{~v, v});
    exp_store[4] = ~v;
    exp_store[5] = v;
    chk("stop level", dis_stop === v, v, dis_stop);
    chk("start level", dis_start === ~v, ~v, dis_start);
    note("start level", ~v, 0);
    note("stop level", v, 0);
    rd(ADDR_DIS_START, 2);
    wr(ADDR_NV_CONTROL, '{8'h04});
    note("control", 8'h00, 0);
    rd(ADDR_NV_CONTROL, 1);
    wr(ADDR_NV_CONTROL, '{8'h01});
    chk("busy", nv_busy === 1'b1, 8'h01, {7'h00, nv_busy});
    for (int i = 0; i < 200 && nv_busy !== 1'b0; i++) cyc(1);
    // The run length is taken at the edge after busy falls, so let that edge pass.
    cyc(1);
    chk("busy length", busy_len >= 95 && busy_len <= 97, 8'd96, busy_len[7:0]);
    for (int i = CFG_FIRST; i <= CFG_LAST; i++) begin
      v = u_dut.nonvolatile_store[i];
      chk("store copy", v === exp_store[i], exp_store[i], v);
    end
    note("control", 8'h00, 0);
    note("control again", 8'h00, 0);
    rd(ADDR_NV_CONTROL, 1);
    rd(ADDR_NV_CONTROL, 1);
    for (int m = 0; m < 2; m++) begin
      v = (m == 0) ? RST_CONVERTER : 8'h45;
      n = 3 + int'(rnd() % 8);
      wr(ADDR_CONVERTER, '{v});
      chk("converter", converter_param === v, v, converter_param);
      wr(ADDR_FREQ_CONFIG, '{RST_FREQ_CONFIG});
      wr(ADDR_FREQ_CONFIG, '{RST_FREQ_CONFIG | 8'h20});
      chk("discharging", discharge_on === 1'b1, 8'h01, {7'h00, discharge_on});
      chk("freq config", freq_cfg === 8'h21, 8'h21, freq_cfg);
      chk("high current", discharge_20ma === (v[7:6] == DISCHARGE_20MA), v,
          {7'h00, discharge_20ma});
      cyc(10);
      below_start = 1'b1;
      cyc(n * TICKS);
      below_stop = 1'b1;
      cyc(3);
      chk("discharge end", discharge_on === 1'b0, 8'h00, {7'h00, discharge_on});
      below_start = 1'b0;
      below_stop = 1'b0;
      for (int r = 0; r < 2; r++) begin
        note("count low", n[7:0], 1);
        note("count high", 8'h00, 0);
        rd(ADDR_RESULT_LOW, 2);
        wr(ADDR_RESULT_LOW, '{8'hAA});
        wr(ADDR_FREQ_CONFIG, '{RST_FREQ_CONFIG | 8'h20});
        chk("no restart", discharge_on === 1'b0, 8'h00, {7'h00, discharge_on});
      end
    end
    results();
  end
endmodule // tb_top
`default_nettype wire
